// ==== pom_pkg.sv ====
// Shared constants, types and helpers for the output macrocell array
package pom_pkg;

  // ==================================================================
  // Array geometry
  localparam int NUM_MC = 10;
  localparam int PT_TOTAL = 120;
  localparam int ADDR_W = 8;

  // ==================================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_MODE_A = 8'h00;
  localparam logic [7:0] ADDR_MODE_B = 8'h04;
  localparam logic [7:0] ADDR_OE_SEL = 8'h08;
  localparam logic [7:0] ADDR_DRAIN = 8'h0c;
  localparam logic [7:0] ADDR_EDGE = 8'h10;
  localparam logic [7:0] ADDR_TERM = 8'h14;
  localparam logic [7:0] ADDR_SIG = 8'h18;
  localparam logic [7:0] ADDR_SECURE = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // ==================================================================
  // Field positions and reset values
  localparam int SEC_LOCK_BIT = 0;
  localparam int SEC_ERASE_BIT = 1;
  localparam int STATUS_POR_BIT = 16;
  localparam logic [9:0] MODE_A_RST = 10'h3ff;
  localparam logic [9:0] MODE_B_RST = 10'h000;
  localparam logic [19:0] OE_SEL_RST = 20'h00000;
  localparam logic [9:0] DRAIN_RST = 10'h000;
  localparam logic [9:0] EDGE_RST = 10'h000;

  // ==================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES = (POR_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : POR_TIME_NS / CLK_PERIOD_NS;

  // ==================================================================
  // Types
  typedef enum logic [1:0] {
    POM_TERM_KEEPER = 2'b00,
    POM_TERM_PULLUP = 2'b01,
    POM_TERM_PULLDOWN = 2'b10,
    POM_TERM_NONE = 2'b11
  } pom_term_t;

  typedef enum logic [1:0] {
    POM_OE_TERM = 2'b00,
    POM_OE_ON = 2'b01,
    POM_OE_OFF = 2'b10
  } pom_oe_mode_t;

  typedef struct packed {
    logic [NUM_MC-1:0] fb_true;
    logic [NUM_MC-1:0] fb_comp;
  } pom_fb_t;

  // Logic terms per macrocell: 8,8,10,10,...,16,16
  function automatic int mc_terms(input int idx);
    return 8 + 2 * (idx / 2);
  endfunction

  function automatic int mc_base(input int idx);
    int acc;
    acc = 0;
    for (int k = 0; k < idx; k++)
    begin
      acc = acc + mc_terms(k);
    end
    return acc;
  endfunction

endpackage

// ==== pom_macrocell_array.sv ====
// Ten output macrocells with shared clear/preset, feedback and APB configuration
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: Ten macrocells summing 8,10,12,14,16 logic terms, two of each size.
// R2: Each macrocell has one extra term used only for output enable.
// R3: Polarity true or inverted per macrocell, in either mode.
// R4: One async clear and one sync preset term shared by all registers.
// R5: Clear term zeroes every flip-flop at once, no clock needed.
// R6: Preset term loads one into every flip-flop at next rising edge.
// R7: Clear and preset act on flip-flop state; pin level follows polarity.
// R8: Two configuration bits per macrocell select mode and polarity.
// R9: Registered mode drives pin from flip-flop after polarity.
// R10: Registered mode enable follows the macrocell's own enable term.
// R11: Registered mode feeds inverted flip-flop output back, both forms.
// R12: Registered pin is output only; its level never feeds the array.
// R13: Combinatorial mode drives pin straight from sum with polarity.
// R14: Combinatorial enable is always on, always off or term driven.
// R15: Combinatorial feedback comes from the pin, true and inverted.
// R16: A reprogrammable 32-bit user signature is readable.
// R17: Signature stays readable whatever the security lock state.
// R18: Each output may be open drain, only pulling low.
// R19: One global input termination: keeper, pull-up, pull-down or none.
// R20: Erased or unspecified termination defaults to pull-up.
// R21: After power-up every register reads zero within about one microsecond.
// R22: Clear and preset together: clear wins, registers hold zero.
module pom_macrocell_array
  import pom_pkg::*;
#(
  parameter logic [31:0] SIG_RST = 32'h0000_0000  // Arbitrary blank signature
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PT_TOTAL-1:0] logic_terms,
  input wire logic [NUM_MC-1:0] oe_terms,
  input wire logic shared_async_clear_term,
  input wire logic shared_sync_preset_term,
  input wire logic [NUM_MC-1:0] pin_in,
  output logic [NUM_MC-1:0] pin_out,
  output logic [NUM_MC-1:0] pin_oe,
  output pom_fb_t feedback,
  output logic [NUM_MC-1:0] edge_rate_bit,
  output pom_term_t term_sel
);

  // ==================================================================
  // Reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==================================================================
  // Power-up hold of the macrocell registers
  logic [7:0] por_cnt_q;
  logic por_busy;

  assign por_busy = (por_cnt_q != 8'(POR_CYCLES));

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      por_cnt_q <= 8'h00;
    else if (por_busy)
      por_cnt_q <= por_cnt_q + 8'h01;
  end

  // ==================================================================
  // Configuration registers
  logic [NUM_MC-1:0] macrocell_cfg_bit_a_q;  // 1: true polarity
  logic [NUM_MC-1:0] macrocell_cfg_bit_b_q;  // 1: combinatorial
  logic [2*NUM_MC-1:0] oe_sel_q;
  logic [NUM_MC-1:0] drain_only_bit_q;
  logic [NUM_MC-1:0] edge_rate_q;
  pom_term_t term_q;
  logic [31:0] user_signature_q;
  logic lock_q;
  logic wr_en;
  logic erase;
  logic cfg_wr;

  assign wr_en = psel & penable & pwrite & pready;
  assign erase = wr_en & (paddr == ADDR_SECURE) & pwdata[SEC_ERASE_BIT];
  // A locked device ignores configuration writes until erased
  assign cfg_wr = wr_en & ~lock_q;

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      macrocell_cfg_bit_a_q <= MODE_A_RST;
      macrocell_cfg_bit_b_q <= MODE_B_RST;
      oe_sel_q <= OE_SEL_RST;
      drain_only_bit_q <= DRAIN_RST;
      edge_rate_q <= EDGE_RST;
    end
    else if (erase)
    begin
      macrocell_cfg_bit_a_q <= MODE_A_RST;
      macrocell_cfg_bit_b_q <= MODE_B_RST;
      oe_sel_q <= OE_SEL_RST;
      drain_only_bit_q <= DRAIN_RST;
      edge_rate_q <= EDGE_RST;
    end
    else if (cfg_wr)
    begin
      if (paddr == ADDR_MODE_A)
        macrocell_cfg_bit_a_q <= pwdata[NUM_MC-1:0];  // R8
      if (paddr == ADDR_MODE_B)
        macrocell_cfg_bit_b_q <= pwdata[NUM_MC-1:0];  // R8
      if (paddr == ADDR_OE_SEL)
        oe_sel_q <= pwdata[2*NUM_MC-1:0];
      if (paddr == ADDR_DRAIN)
        drain_only_bit_q <= pwdata[NUM_MC-1:0];
      if (paddr == ADDR_EDGE)
        edge_rate_q <= pwdata[NUM_MC-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      term_q <= POM_TERM_PULLUP;  // R20
    else if (erase)
      term_q <= POM_TERM_PULLUP;  // R20
    else if (cfg_wr && paddr == ADDR_TERM)
      term_q <= pom_term_t'(pwdata[1:0]);  // R19
  end

  // Signature stays writable and readable regardless of the lock
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      user_signature_q <= SIG_RST;
    else if (erase)
      user_signature_q <= SIG_RST;
    else if (wr_en && paddr == ADDR_SIG)
      user_signature_q <= pwdata;  // R16
  end

  // Lock only sets by write; only reset or an erase clears it
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      lock_q <= 1'b0;
    else if (erase)
      lock_q <= 1'b0;
    else if (wr_en && paddr == ADDR_SECURE && pwdata[SEC_LOCK_BIT])
      lock_q <= 1'b1;
  end

  assign edge_rate_bit = edge_rate_q;
  assign term_sel = term_q;

  // ==================================================================
  // Sum terms
  logic [NUM_MC-1:0] sum;

  always_comb
  begin
    for (int i = 0; i < NUM_MC; i++)
    begin
      sum[i] = 1'b0;
      for (int t = 0; t < mc_terms(i); t++)
      begin
        sum[i] = sum[i] | logic_terms[mc_base(i) + t];  // R1
      end
    end
  end

  // ==================================================================
  // Macrocell flip-flops
  logic [NUM_MC-1:0] mc_q;

  // Clear is an asynchronous input of the flop and so beats preset
  always_ff @(posedge clk or negedge rst_n_q or posedge shared_async_clear_term)
  begin
    if (!rst_n_q)
      mc_q <= '0;
    else if (shared_async_clear_term)
      mc_q <= '0;  // R4 R5 R22
    else if (por_busy)
      mc_q <= '0;  // R21
    else if (shared_sync_preset_term)
      mc_q <= '1;  // R4 R6
    else
      mc_q <= sum;
  end

  // ==================================================================
  // Pin drive, enables and feedback
  logic [NUM_MC-1:0] level;
  logic [NUM_MC-1:0] oe_raw;

  always_comb
  begin
    for (int i = 0; i < NUM_MC; i++)
    begin
      // Polarity is applied after the flop, so clear/preset are polarity blind
      level[i] = (macrocell_cfg_bit_b_q[i] ? sum[i] : mc_q[i]) ^ ~macrocell_cfg_bit_a_q[i];  // R3 R7 R9 R13
      if (!macrocell_cfg_bit_b_q[i])
        oe_raw[i] = oe_terms[i];  // R2 R10
      else
      begin
        unique case (pom_oe_mode_t'(oe_sel_q[2*i +: 2]))
          POM_OE_ON: oe_raw[i] = 1'b1;  // R14
          POM_OE_OFF: oe_raw[i] = 1'b0;  // R14
          default: oe_raw[i] = oe_terms[i];  // R14
        endcase
      end
      // Open drain drives only low and releases otherwise
      pin_out[i] = drain_only_bit_q[i] ? 1'b0 : level[i];  // R18
      pin_oe[i] = oe_raw[i] & ~(drain_only_bit_q[i] & level[i]);  // R18
      // Registered pins feed back the inverted flop, never the pin
      feedback.fb_true[i] = macrocell_cfg_bit_b_q[i] ? pin_in[i] : ~mc_q[i];  // R11 R12 R15
      feedback.fb_comp[i] = macrocell_cfg_bit_b_q[i] ? ~pin_in[i] : mc_q[i];  // R11 R12 R15
    end
  end

  // ==================================================================
  // APB slave: no wait states, answer registered in the setup cycle
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic hit_d;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      ADDR_MODE_A: rd_d[NUM_MC-1:0] = lock_q ? '0 : macrocell_cfg_bit_a_q;
      ADDR_MODE_B: rd_d[NUM_MC-1:0] = lock_q ? '0 : macrocell_cfg_bit_b_q;
      ADDR_OE_SEL: rd_d[2*NUM_MC-1:0] = lock_q ? '0 : oe_sel_q;
      ADDR_DRAIN: rd_d[NUM_MC-1:0] = lock_q ? '0 : drain_only_bit_q;
      ADDR_EDGE: rd_d[NUM_MC-1:0] = lock_q ? '0 : edge_rate_q;
      ADDR_TERM: rd_d[1:0] = lock_q ? 2'b00 : term_q;
      ADDR_SIG: rd_d = user_signature_q;  // R17
      ADDR_SECURE: rd_d[SEC_LOCK_BIT] = lock_q;
      ADDR_STATUS:
      begin
        rd_d[NUM_MC-1:0] = mc_q;
        rd_d[STATUS_POR_BIT] = por_busy;
      end
      default: hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit_d;
      if (psel && !penable && !pwrite)
        prdata_q <= rd_d;
      else if (!psel)
        prdata_q <= 32'h0000_0000;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // ==================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_q);

  logic [NUM_MC-1:0] reg_nd;
  logic [NUM_MC-1:0] comb_nd;
  assign reg_nd = ~macrocell_cfg_bit_b_q & ~drain_only_bit_q;
  assign comb_nd = macrocell_cfg_bit_b_q & ~drain_only_bit_q;

  sequence s_sig_setup;
    psel && !penable && !pwrite && paddr == ADDR_SIG;
  endsequence

  property p_clear;
    shared_async_clear_term |-> mc_q == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left a register set");  // R5

  property p_preset;
    shared_sync_preset_term && !shared_async_clear_term && !por_busy |=> mc_q == '1 || shared_async_clear_term;
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not load ones");  // R6

  property p_both;
    shared_sync_preset_term && shared_async_clear_term |=> mc_q == '0 || !$past(shared_async_clear_term);
  endproperty
  a_both: assert property (p_both) else $error("preset beat clear");  // R22

  property p_load;
    !shared_sync_preset_term && !por_busy && !shared_async_clear_term |=> mc_q == $past(sum) || shared_async_clear_term;
  endproperty
  a_load: assert property (p_load) else $error("register missed sum");  // R9

  property p_reg_pin;
    (reg_nd & (pin_out ^ mc_q ^ ~macrocell_cfg_bit_a_q)) == '0;
  endproperty
  a_reg_pin: assert property (p_reg_pin) else $error("registered pin level wrong");  // R3 R7 R9

  property p_comb_pin;
    (comb_nd & (pin_out ^ sum ^ ~macrocell_cfg_bit_a_q)) == '0;
  endproperty
  a_comb_pin: assert property (p_comb_pin) else $error("combinatorial pin level wrong");  // R13

  property p_reg_oe;
    (reg_nd & (pin_oe ^ oe_terms)) == '0;
  endproperty
  a_reg_oe: assert property (p_reg_oe) else $error("registered enable wrong");  // R10

  property p_fb;
    ((~macrocell_cfg_bit_b_q & (feedback.fb_true ^ ~mc_q))
      | (macrocell_cfg_bit_b_q & (feedback.fb_true ^ pin_in))) == '0;
  endproperty
  a_fb: assert property (p_fb) else $error("feedback source wrong");  // R11 R12 R15

  property p_drain;
    (drain_only_bit_q & pin_out) == '0;
  endproperty
  a_drain: assert property (p_drain) else $error("open drain drove high");  // R18

  property p_por;
    por_busy |=> mc_q == '0;
  endproperty
  a_por: assert property (p_por) else $error("register set during power-up");  // R21

  property p_sig;
    s_sig_setup ##1 (psel && penable) |-> pready && prdata == user_signature_q;
  endproperty
  a_sig: assert property (p_sig) else $error("signature read wrong");  // R16 R17

  property p_ready;
    psel && !penable |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");

endmodule

`default_nettype wire

// ==== pom_board_model.sv ====
// Board model: resolves each pin from device drive, board drive and termination
`timescale 1ns/1ps
`default_nettype none
module pom_board_model
  import pom_pkg::*;
(
  input wire logic clk,
  input wire logic [NUM_MC-1:0] pin_out,
  input wire logic [NUM_MC-1:0] pin_oe,
  input wire logic [NUM_MC-1:0] ext_drv,
  input wire logic [NUM_MC-1:0] ext_val,
  input wire pom_term_t term_sel,
  output logic [NUM_MC-1:0] pin_in
);
  // ==================================================================
  // Wire resolution
  logic [NUM_MC-1:0] last_q = '0;

  always_ff @(posedge clk)
  begin
    last_q <= pin_in;
  end

  // Undriven pins with no termination flip each cycle, so no stale value can pass
  always_comb
  begin
    for (int i = 0; i < NUM_MC; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_drv[i])
        pin_in[i] = ext_val[i];
      else if (term_sel == POM_TERM_PULLUP)
        pin_in[i] = 1'b1;
      else if (term_sel == POM_TERM_PULLDOWN)
        pin_in[i] = 1'b0;
      else if (term_sel == POM_TERM_KEEPER)
        pin_in[i] = last_q[i];
      else
        pin_in[i] = ~last_q[i];
    end
  end
endmodule
`default_nettype wire

// ==== pld_output_macrocell_array_tb_top.sv ====
// Self-checking testbench for the output macrocell array
`timescale 1ns/1ps
`default_nettype none
module pld_output_macrocell_array_tb_top
  import pom_pkg::*;
;
  // ==================================================================
  // Signals
  localparam logic [31:0] SIG = 32'h5a3c_0f96;  // Arbitrary signature value
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, clr, pre;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, sv;
  logic [PT_TOTAL-1:0] lt;
  logic [NUM_MC-1:0] oet, pin_in, pin_out, pin_oe, edge_q, ext_drv, ext_val, pol, q, en;
  logic [19:0] sel;
  pom_fb_t fb;
  pom_term_t term;
  integer seed = 32'hbe1b;
  int failures = 0;
  int n_checks = 0;
  logic [32:0] expq[$];
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h24};
  logic [32:0] re [8] = '{33'h3ff, 33'h0, 33'h0, 33'h0, 33'h0, 33'h1, {1'b0, SIG}, 33'h1_0000_0000};

  always #12.5 clk = ~clk;

  pom_macrocell_array #(.SIG_RST(SIG)) dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .logic_terms(lt), .oe_terms(oet), .shared_async_clear_term(clr), .shared_sync_preset_term(pre),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .feedback(fb), .edge_rate_bit(edge_q), .term_sel(term));

  pom_board_model board_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv),
    .ext_val(ext_val), .term_sel(term), .pin_in(pin_in));

  // ==================================================================
  // Tasks
  function automatic logic [NUM_MC-1:0] sums(input logic [PT_TOTAL-1:0] t);
    int b;
    int n;
    b = 0;
    sums = '0;
    for (int i = 0; i < NUM_MC; i++)
    begin
      n = 8 + 2 * (i / 2);
      sums[i] = |((t >> b) & ((120'h1 << n) - 120'h1));
      b = b + n;
    end
  endfunction

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w)
      expq.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // No cycle budget here: only the watchdog ends a stuck transfer
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Read answers are compared against the oldest noted expectation
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      chk({pslverr, prdata}, expq.pop_front());
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end

  // ==================================================================
  // Main sequence
  initial
  begin
    {clk, reset_n, psel, penable, pwrite, clr, pre} = '0;
    {paddr, pwdata, lt, oet, ext_drv, ext_val} = '0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    lt <= '1;
    repeat (3) @(posedge clk);
    apb(0, ADDR_STATUS, 0, 33'h1_0000);
    repeat (POR_CYCLES) @(posedge clk);
    apb(0, ADDR_STATUS, 0, 33'h3ff);
    for (int i = 0; i < 8; i++)
      apb(0, ra[i], 0, re[i]);
    chk(term, POM_TERM_PULLUP);
    $display("test reset done");
    repeat (6)
    begin
      pol = 10'($random(seed));
      apb(1, ADDR_MODE_A, {22'h0, pol}, 0);
      lt <= {$random(seed), $random(seed), $random(seed), 24'($random(seed))};
      oet <= 10'($random(seed));
      ext_drv <= 10'($random(seed));
      ext_val <= 10'($random(seed));
      repeat (2) @(posedge clk);
      #1;
      q = sums(lt);
      chk(pin_out, 10'(q ^ ~pol));
      chk(pin_oe, oet);
      chk(fb, {~q, q});
      @(posedge clk);
    end
    $display("test registered done");
    clr <= 1'b1;
    #1;
    chk(pin_out, 10'(~pol));
    @(posedge clk);
    pre <= 1'b1;
    @(posedge clk);
    #1;
    chk(pin_out, 10'(~pol));
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
    #1;
    chk(pin_out, pol);
    @(posedge clk);
    apb(0, ADDR_STATUS, 0, 33'h3ff);
    pre <= 1'b0;
    $display("test clear preset done");
    apb(1, ADDR_MODE_B, 32'h3ff, 0);
    repeat (6)
    begin
      pol = 10'($random(seed));
      sel = 20'($random(seed));
      apb(1, ADDR_MODE_A, {22'h0, pol}, 0);
      apb(1, ADDR_OE_SEL, {12'h0, sel}, 0);
      lt <= {$random(seed), $random(seed), $random(seed), 24'($random(seed))};
      oet <= 10'($random(seed));
      ext_drv <= 10'($random(seed));
      ext_val <= 10'($random(seed));
      @(posedge clk);
      #1;
      q = sums(lt) ^ ~pol;
      for (int i = 0; i < NUM_MC; i++)
        en[i] = (sel[2*i+:2] == 2'b01) ? 1'b1 : (sel[2*i+:2] == 2'b10) ? 1'b0 : oet[i];
      chk(pin_out, q);
      chk(pin_oe, en);
      chk(fb, {pin_in, ~pin_in});
      @(posedge clk);
    end
    apb(1, ADDR_DRAIN, 32'h3ff, 0);
    #1;
    chk(pin_out, 0);
    chk(pin_oe, en & ~q);
    @(posedge clk);
    apb(1, ADDR_DRAIN, 0, 0);
    $display("test combinatorial done");
    sv = $random(seed);
    apb(1, ADDR_EDGE, sv, 0);
    chk(edge_q, sv[9:0]);
    apb(1, ADDR_OE_SEL, 32'haaaaa, 0);
    ext_drv <= '0;
    for (int t = 0; t < 4; t++)
    begin
      apb(1, ADDR_TERM, t, 0);
      chk(term, t);
      // Keeper holds the pulled-up level left by the reset termination
      if (t < 3)
        chk(pin_in, (t == 2) ? 10'h0 : 10'h3ff);
    end
    $display("test io options done");
    sv = $random(seed);
    apb(1, ADDR_SIG, sv, 0);
    apb(1, ADDR_SECURE, 32'h1, 0);
    apb(0, ADDR_SIG, 0, {1'b0, sv});
    apb(1, ADDR_MODE_A, 32'h0, 0);
    apb(0, ADDR_MODE_A, 0, 33'h0);
    apb(1, ADDR_SECURE, 32'h2, 0);
    apb(0, ADDR_SIG, 0, {1'b0, SIG});
    apb(0, ADDR_MODE_A, 0, 33'h3ff);
    apb(0, ADDR_TERM, 0, 33'h1);
    $display("test signature done");
    summarize();
  end
endmodule
`default_nettype wire
